// ===== common/wtc_cmp_if.sv
// Signals between the threshold bank and the warning comparator.
`timescale 1ns/1ps
interface wtc_cmp_if;
   logic [7:0] temp_high_thr;
   logic [7:0] temp_low_thr;
   logic [7:0] volt_high_thr;
   logic [7:0] measured_temp_upper;
   logic [7:0] measured_supply_upper;
   logic meas_store;
   logic warn_temp_high;
   logic warn_temp_low;
   logic warn_volt_high;

   modport bank (
      output temp_high_thr,
      output temp_low_thr,
      output volt_high_thr,
      output measured_temp_upper,
      output measured_supply_upper,
      output meas_store,
      input warn_temp_high,
      input warn_temp_low,
      input warn_volt_high
   );

   modport compare (
      input temp_high_thr,
      input temp_low_thr,
      input volt_high_thr,
      input measured_temp_upper,
      input measured_supply_upper,
      input meas_store,
      output warn_temp_high,
      output warn_temp_low,
      output warn_volt_high
   );
endinterface

// ===== common/wtc_pkg.sv
// Shared constants and types of the warning threshold compare block.
package wtc_pkg;

   // Seven-bit serial address of the management page holding the bank.
   localparam logic [6:0] SERIAL_ADDR = 7'h51;

   // Byte addresses of the threshold registers.
   localparam logic [7:0] OFS_TEMP_HIGH_WARN_UPPER = 8'h04;
   localparam logic [7:0] OFS_TEMP_HIGH_WARN_LOWER = 8'h05;
   localparam logic [7:0] OFS_TEMP_LOW_WARN_UPPER = 8'h06;
   localparam logic [7:0] OFS_TEMP_LOW_WARN_LOWER = 8'h07;
   localparam logic [7:0] OFS_VOLT_HIGH_WARN_UPPER = 8'h0C;
   localparam logic [7:0] OFS_VOLT_HIGH_WARN_LOWER = 8'h0D;

   // Storage slots of the bank; the none code marks an unmapped address.
   localparam int NUM_THR = 6;
   localparam logic [2:0] IDX_TEMP_HIGH_UPPER = 3'h0;
   localparam logic [2:0] IDX_TEMP_HIGH_LOWER = 3'h1;
   localparam logic [2:0] IDX_TEMP_LOW_UPPER = 3'h2;
   localparam logic [2:0] IDX_TEMP_LOW_LOWER = 3'h3;
   localparam logic [2:0] IDX_VOLT_HIGH_UPPER = 3'h4;
   localparam logic [2:0] IDX_VOLT_HIGH_LOWER = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h7;

   localparam logic [7:0] THR_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Scales of the threshold bytes.
   localparam int TEMP_UPPER_LSB_MDEGC = 1000;
   localparam int VOLT_UPPER_LSB_UV = 25600;
   localparam int VOLT_LOWER_LSB_UV = 100;

   typedef enum logic [2:0] {
      WTC_IDLE = 3'b000,
      WTC_ADDR = 3'b001,
      WTC_ACK_ADDR = 3'b010,
      WTC_WRITE = 3'b011,
      WTC_ACK_WRITE = 3'b100,
      WTC_READ = 3'b101,
      WTC_ACK_READ = 3'b110
   } wtc_state_type;

endpackage

// ===== src/wtc_compare.sv
// Warning comparator: upper bytes of measurements against thresholds.
`timescale 1ns/1ps
module wtc_compare #(
   parameter int W = 8,
   parameter bit TEMP_SIGNED = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   wtc_cmp_if.compare bus
);

   if (W != 8) begin : g_width_check
      $error("wtc_compare serves byte-wide comparisons only");
   end
   if (wtc_pkg::VOLT_UPPER_LSB_UV != 256 * wtc_pkg::VOLT_LOWER_LSB_UV)
   begin : g_scale_check
      $error("voltage upper byte step must be 256 lower steps");
   end

   typedef struct packed {
      logic temp_high;
      logic temp_low;
      logic volt_high;
   } wtc_flags_type;

   wtc_flags_type cur;
   wtc_flags_type next_cur;

   function automatic logic above(input logic [W-1:0] a,
                                  input logic [W-1:0] b,
                                  input logic sgn);
      above = sgn ? ($signed(a) > $signed(b)) : (a > b);
   endfunction

   // Flags follow the raw measurement and only change when a new one is
   // stored, so a flag clears on the next store after its cause is gone.
   always_comb begin
      next_cur = cur;
      if (bus.meas_store) begin
         // Raw bytes, no calibration; both sides on the same degree scale.
         next_cur.temp_high = above(bus.measured_temp_upper,
            bus.temp_high_thr, TEMP_SIGNED);
         next_cur.temp_low = above(bus.temp_low_thr,
            bus.measured_temp_upper, TEMP_SIGNED);
         // Upper byte steps of 25.6 mV on both sides.
         next_cur.volt_high = above(bus.measured_supply_upper,
            bus.volt_high_thr, 1'b0);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign bus.warn_temp_high = cur.temp_high;
   assign bus.warn_temp_low = cur.temp_low;
   assign bus.warn_volt_high = cur.volt_high;

endmodule // wtc_compare

// ===== src/wtc_top.sv
// Warning threshold bank on the two-wire management bus, with comparator.
// How it works
// - Temperature-high warning when measured upper byte exceeds its threshold.
// - Temperature-low warning when measured upper byte is below its threshold.
// - Voltage-high warning when measured supply upper byte exceeds threshold.
// - Temperature threshold upper byte counts whole degrees, like the reading.
// - Voltage threshold upper byte counts 25.6 mV steps.
// - Voltage lower byte is the low half of a 100 uV sixteen-bit value.
// - Each threshold is upper byte above lower byte, sixteen bits.
// - Lower threshold bytes are stored but never compared.
// - Comparisons use raw readings; thresholds are never calibrated.
`timescale 1ns/1ps
module wtc_top #(
   parameter bit TEMP_SIGNED = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic meas_store,
   input wire logic [7:0] measured_temp_upper,
   input wire logic [7:0] measured_supply_upper,
   output logic warn_temp_high,
   output logic warn_temp_low,
   output logic warn_volt_high
);

   typedef struct packed {
      logic scl_meta;
      logic scl_sync;
      logic scl_prev;
      logic sda_meta;
      logic sda_sync;
      logic sda_prev;
      wtc_pkg::wtc_state_type state;
      logic [3:0] bit_count;
      logic [7:0] shift;
      logic read_dir;
      logic ptr_pending;
      logic [7:0] ptr;
      logic sda_drive;
      logic [wtc_pkg::NUM_THR-1:0][7:0] thr;
   } wtc_bank_type;

   wtc_bank_type cur;
   wtc_bank_type next_cur;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [2:0] wr_idx;
   logic [7:0] rd_data;

   wtc_cmp_if cmp_bus ();

   function automatic logic [2:0] thr_index(input logic [7:0] a);
      case (a)
         wtc_pkg::OFS_TEMP_HIGH_WARN_UPPER:
            thr_index = wtc_pkg::IDX_TEMP_HIGH_UPPER;
         wtc_pkg::OFS_TEMP_HIGH_WARN_LOWER:
            thr_index = wtc_pkg::IDX_TEMP_HIGH_LOWER;
         wtc_pkg::OFS_TEMP_LOW_WARN_UPPER:
            thr_index = wtc_pkg::IDX_TEMP_LOW_UPPER;
         wtc_pkg::OFS_TEMP_LOW_WARN_LOWER:
            thr_index = wtc_pkg::IDX_TEMP_LOW_LOWER;
         wtc_pkg::OFS_VOLT_HIGH_WARN_UPPER:
            thr_index = wtc_pkg::IDX_VOLT_HIGH_UPPER;
         wtc_pkg::OFS_VOLT_HIGH_WARN_LOWER:
            thr_index = wtc_pkg::IDX_VOLT_HIGH_LOWER;
         default:
            thr_index = wtc_pkg::IDX_NONE;
      endcase
   endfunction

   // Only the synchronised and delayed copies are looked at, never the
   // first stage of either pin synchroniser.
   assign scl_rise = cur.scl_sync & ~cur.scl_prev;
   assign scl_fall = ~cur.scl_sync & cur.scl_prev;
   assign bus_start = cur.scl_sync & cur.scl_prev & cur.sda_prev &
      ~cur.sda_sync;
   assign bus_stop = cur.scl_sync & cur.scl_prev & ~cur.sda_prev &
      cur.sda_sync;

   always_comb begin
      wr_idx = thr_index(cur.ptr);
      rd_data = (thr_index(cur.ptr) == wtc_pkg::IDX_NONE) ?
         wtc_pkg::UNMAPPED_READ : cur.thr[thr_index(cur.ptr)];
   end

   always_comb begin
      next_cur = cur;
      next_cur.scl_meta = scl_in;
      next_cur.scl_sync = cur.scl_meta;
      next_cur.scl_prev = cur.scl_sync;
      next_cur.sda_meta = sda_in;
      next_cur.sda_sync = cur.sda_meta;
      next_cur.sda_prev = cur.sda_sync;
      if (bus_start) begin
         next_cur.state = wtc_pkg::WTC_ADDR;
         next_cur.bit_count = '0;
         next_cur.sda_drive = 1'b0;
         next_cur.ptr_pending = 1'b1;
      end else if (bus_stop) begin
         next_cur.state = wtc_pkg::WTC_IDLE;
         next_cur.sda_drive = 1'b0;
      end else begin
         unique case (cur.state)
            wtc_pkg::WTC_IDLE: begin
            end
            wtc_pkg::WTC_ADDR, wtc_pkg::WTC_WRITE: begin
               if (scl_rise) begin
                  next_cur.shift = {cur.shift[6:0], cur.sda_sync};
                  next_cur.bit_count = cur.bit_count + 4'h1;
               end else if (scl_fall &&
                            cur.bit_count == wtc_pkg::BITS_PER_BYTE) begin
                  next_cur.bit_count = '0;
                  if (cur.state == wtc_pkg::WTC_ADDR) begin
                     if (cur.shift[7:1] == wtc_pkg::SERIAL_ADDR) begin
                        next_cur.state = wtc_pkg::WTC_ACK_ADDR;
                        next_cur.sda_drive = 1'b1;
                        next_cur.read_dir = cur.shift[0];
                     end else begin
                        next_cur.state = wtc_pkg::WTC_IDLE;
                     end
                  end else begin
                     next_cur.state = wtc_pkg::WTC_ACK_WRITE;
                     next_cur.sda_drive = 1'b1;
                     if (cur.ptr_pending) begin
                        next_cur.ptr = cur.shift;
                        next_cur.ptr_pending = 1'b0;
                     end else begin
                        // Lower bytes are kept whole so the host reads back
                        // the sixteen-bit value it wrote.
                        if (wr_idx != wtc_pkg::IDX_NONE) begin
                           next_cur.thr[wr_idx] = cur.shift;
                        end
                        next_cur.ptr = cur.ptr + 8'h01;
                     end
                  end
               end
            end
            wtc_pkg::WTC_ACK_ADDR: begin
               if (scl_fall) begin
                  if (cur.read_dir) begin
                     next_cur.state = wtc_pkg::WTC_READ;
                     next_cur.shift = rd_data;
                     next_cur.sda_drive = ~rd_data[7];
                     next_cur.ptr = cur.ptr + 8'h01;
                  end else begin
                     next_cur.state = wtc_pkg::WTC_WRITE;
                     next_cur.sda_drive = 1'b0;
                  end
               end
            end
            wtc_pkg::WTC_ACK_WRITE: begin
               if (scl_fall) begin
                  next_cur.state = wtc_pkg::WTC_WRITE;
                  next_cur.sda_drive = 1'b0;
               end
            end
            wtc_pkg::WTC_READ: begin
               if (scl_rise) begin
                  next_cur.bit_count = cur.bit_count + 4'h1;
               end else if (scl_fall) begin
                  if (cur.bit_count == wtc_pkg::BITS_PER_BYTE) begin
                     next_cur.state = wtc_pkg::WTC_ACK_READ;
                     next_cur.sda_drive = 1'b0;
                     next_cur.bit_count = '0;
                  end else begin
                     next_cur.shift = {cur.shift[6:0], 1'b0};
                     next_cur.sda_drive = ~cur.shift[6];
                  end
               end
            end
            wtc_pkg::WTC_ACK_READ: begin
               // A host that does not acknowledge ends the read burst.
               if (scl_rise && cur.sda_sync) begin
                  next_cur.state = wtc_pkg::WTC_IDLE;
               end else if (scl_fall) begin
                  next_cur.state = wtc_pkg::WTC_READ;
                  next_cur.shift = rd_data;
                  next_cur.sda_drive = ~rd_data[7];
                  next_cur.ptr = cur.ptr + 8'h01;
               end
            end
            default: begin
               next_cur.state = wtc_pkg::WTC_IDLE;
               next_cur.sda_drive = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '{scl_meta: 1'b1, scl_sync: 1'b1, scl_prev: 1'b1,
                  sda_meta: 1'b1, sda_sync: 1'b1, sda_prev: 1'b1,
                  state: wtc_pkg::WTC_IDLE, bit_count: 4'h0,
                  shift: 8'h00, read_dir: 1'b0, ptr_pending: 1'b0,
                  ptr: 8'h00, sda_drive: 1'b0,
                  thr: {wtc_pkg::NUM_THR{wtc_pkg::THR_RESET}}};
      end else begin
         cur <= next_cur;
      end
   end

   // Only the upper bytes reach the comparator; the lower bytes stop here.
   assign cmp_bus.temp_high_thr =
      cur.thr[wtc_pkg::IDX_TEMP_HIGH_UPPER];
   assign cmp_bus.temp_low_thr =
      cur.thr[wtc_pkg::IDX_TEMP_LOW_UPPER];
   assign cmp_bus.volt_high_thr =
      cur.thr[wtc_pkg::IDX_VOLT_HIGH_UPPER];
   assign cmp_bus.measured_temp_upper = measured_temp_upper;
   assign cmp_bus.measured_supply_upper = measured_supply_upper;
   assign cmp_bus.meas_store = meas_store;

   wtc_compare #(
      .W(8),
      .TEMP_SIGNED(TEMP_SIGNED)
   ) u_compare (
      .clk(clk),
      .resetn(resetn),
      .bus(cmp_bus)
   );

   // Open-drain: the pin is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe = cur.sda_drive;
   assign warn_temp_high = cmp_bus.warn_temp_high;
   assign warn_temp_low = cmp_bus.warn_temp_low;
   assign warn_volt_high = cmp_bus.warn_volt_high;

endmodule // wtc_top

// ===== tb/wtc_checker.sv
// Port assertions of the warning threshold compare block.
`timescale 1ns/1ps
module wtc_checker #(
   parameter bit TEMP_SIGNED = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic meas_store,
   input wire logic [7:0] measured_temp_upper,
   input wire logic [7:0] measured_supply_upper,
   input wire logic warn_temp_high,
   input wire logic warn_temp_low,
   input wire logic warn_volt_high
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_reset_quiet: assert property ($rose(resetn) |-> !sda_oe &&
      !warn_temp_high && !warn_temp_low && !warn_volt_high)
      else $error("outputs not quiet after reset");
   a_flags_hold: assert property (!meas_store |=>
      $stable({warn_temp_high, warn_temp_low, warn_volt_high}))
      else $error("flag moved without a stored measurement");
   a_temp_min_high: assert property (meas_store && TEMP_SIGNED &&
      measured_temp_upper == 8'h80 |=> !warn_temp_high)
      else $error("lowest temperature raised high warning");
   a_temp_max_low: assert property (meas_store && TEMP_SIGNED &&
      measured_temp_upper == 8'h7F |=> !warn_temp_low)
      else $error("highest temperature raised low warning");
   a_volt_zero_high: assert property (meas_store &&
      measured_supply_upper == 8'h00 |=> !warn_volt_high)
      else $error("zero supply raised high warning");
   a_oe_scl_low: assert property ($changed(sda_oe) |->
      !scl_in && !$past(scl_in)) else $error("data pin moved with clock high");
   a_drive_zero: assert property (sda_out == 1'b0)
      else $error("data pin drive value not low");
   a_stop_release: assert property (scl_in && $rose(sda_in) |=>
      !sda_oe [*2]) else $error("data pin held after stop");
   cover property (meas_store ##1 warn_temp_high);
   cover property (meas_store ##1 warn_temp_low && warn_volt_high);
   cover property ($rose(sda_oe));
endmodule // wtc_checker
bind wtc_top wtc_checker #(.TEMP_SIGNED(TEMP_SIGNED)) u_wtc_checker (
   .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .meas_store(meas_store),
   .measured_temp_upper(measured_temp_upper),
   .measured_supply_upper(measured_supply_upper),
   .warn_temp_high(warn_temp_high), .warn_temp_low(warn_temp_low),
   .warn_volt_high(warn_volt_high));

// ===== tb/wtc_host_model.sv
// Two-wire host controller model driving the management bus.
`timescale 1ns/1ps
module wtc_host_model (
   input wire logic clk,
   input wire logic dev_oe,
   output logic scl,
   output logic sda
);
   logic pull_low = 1'b0;
   // A released wire floats high through the pull-up, never holding data.
   assign sda = ~(pull_low | dev_oe);
   initial scl = 1'b1;
   task automatic hp;
      repeat (8) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      hp;
      pull_low <= ~b;
      hp;
      scl <= 1'b1;
      hp;
      r = sda;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                          output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ack);
   endtask
   task automatic edge_pair(input logic first);
      scl <= 1'b0;
      hp;
      pull_low <= first;
      hp;
      scl <= 1'b1;
      hp;
      pull_low <= ~first;
      hp;
   endtask
   // A single-byte read ends with the host NACK, as the last byte must.
   task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr,
                       input logic rd, input logic [7:0] wd,
                       output logic [7:0] q, output logic [2:0] acks);
      logic [7:0] tmp;
      logic nk;
      edge_pair(1'b0);
      byte_io({dev, 1'b0}, tmp, acks[2]);
      byte_io(ptr, tmp, acks[1]);
      if (rd) begin
         edge_pair(1'b0);
         byte_io({dev, 1'b1}, tmp, acks[0]);
         byte_io(8'hFF, q, nk);
      end else begin
         byte_io(wd, tmp, acks[0]);
      end
      edge_pair(1'b1);
   endtask
endmodule // wtc_host_model

// ===== tb/wtc_top_tb_top.sv
// Self-checking bench of the warning threshold compare block.
`timescale 1ns/1ps
module wtc_top_tb_top;
   typedef struct {
      logic [7:0] t;
      logic [7:0] s;
      logic [2:0] f;
   } wtc_row_type;
   logic clk, resetn, meas_store;
   logic [7:0] temp, supply, q;
   logic [2:0] k;
   wire scl, sda, sda_oe, sda_out, w_th, w_tl, w_vh;
   wire [2:0] flags = {w_th, w_tl, w_vh};
   int mismatches = 0;
   int n_compared = 0;
   logic [7:0] adr [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D};
   logic [7:0] val [6] = '{8'h30, 8'h00, 8'hF6, 8'hFF, 8'h82, 8'h00};
   wtc_row_type rows [8] = '{'{8'h31, 8'h82, 3'h4}, '{8'h30, 8'h83, 3'h1},
      '{8'hF6, 8'h00, 3'h0}, '{8'hF5, 8'hFF, 3'h3}, '{8'h80, 8'h82, 3'h2},
      '{8'h7F, 8'h81, 3'h4}, '{8'h00, 8'h7F, 3'h0}, '{8'hFF, 8'h83, 3'h1}};
   wtc_top u_wtc_top (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .meas_store(meas_store),
      .measured_temp_upper(temp), .measured_supply_upper(supply),
      .warn_temp_high(w_th), .warn_temp_low(w_tl), .warn_volt_high(w_vh));
   wtc_host_model u_wtc_host_model (.clk(clk), .dev_oe(sda_oe), .scl(scl),
      .sda(sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compared=%0d mismatches=%0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic rd,
                      input logic [7:0] d);
      u_wtc_host_model.xfer(wtc_pkg::SERIAL_ADDR, a, rd, d, q, k);
      chk({5'h00, k}, 8'h00);
   endtask
   task automatic pulse;
      @(posedge clk);
      meas_store <= 1'b1;
      @(posedge clk);
      meas_store <= 1'b0;
      #1;
   endtask
   task automatic do_reset;
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      resetn = 1'b0;
      meas_store = 1'b0;
      temp = 8'h00;
      supply = 8'h00;
      do_reset;
      for (int i = 0; i < 6; i++) bus(adr[i], 1'b0, val[i]);
      for (int i = 0; i < 6; i++) begin
         bus(adr[i], 1'b1, 8'h00);
         chk(q, val[i]);
      end
      $display("test register access done");
      // Stores run back to back so each flag is judged one cycle later.
      for (int i = 0; i <= 8; i++) begin
         @(posedge clk);
         meas_store <= (i < 8);
         if (i < 8) begin
            temp <= rows[i].t;
            supply <= rows[i].s;
         end
         #1;
         if (i > 0) chk({5'h00, flags}, {5'h00, rows[i-1].f});
      end
      $display("test compare table done");
      bus(8'h0C, 1'b0, 8'hFF);
      chk({5'h00, flags}, 8'h01);
      pulse;
      chk({5'h00, flags}, 8'h00);
      $display("test late threshold done");
      bus(8'h08, 1'b0, 8'hA5);
      bus(8'h08, 1'b1, 8'h00);
      chk(q, 8'h00);
      u_wtc_host_model.xfer(7'h52, 8'h04, 1'b0, 8'h11, q, k);
      chk({5'h00, k}, 8'h07);
      bus(8'h04, 1'b1, 8'h00);
      chk(q, 8'h30);
      $display("test unmapped and foreign address done");
      temp <= 8'h40;
      pulse;
      chk({5'h00, flags}, 8'h04);
      do_reset;
      chk({5'h00, flags}, 8'h00);
      for (int i = 0; i < 6; i++) begin
         bus(adr[i], 1'b1, 8'h00);
         chk(q, 8'h00);
      end
      $display("test second reset done");
      end_sim;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_sim;
   end
endmodule // wtc_top_tb_top
